// ### design/pth_pkg.sv
// package: mode codes, widths and timing constants for the period timer
package pth_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W = 8;
  localparam int unsigned MODE_W = 5;
  localparam int unsigned POST_W = 4;
  localparam int unsigned SYNC_STAGES = 2;

  // ----------------------------------------------------------------------
  // mode codes
  // ----------------------------------------------------------------------
  localparam logic [MODE_W-1:0] MD_SW_GATE = 5'h00;
  localparam logic [MODE_W-1:0] MD_HW_GATE_HI = 5'h01;
  localparam logic [MODE_W-1:0] MD_HW_GATE_LO = 5'h02;
  localparam logic [MODE_W-1:0] MD_LIM_ANY = 5'h03;
  localparam logic [MODE_W-1:0] MD_LIM_RISE = 5'h04;
  localparam logic [MODE_W-1:0] MD_LIM_FALL = 5'h05;
  localparam logic [MODE_W-1:0] MD_LIM_LVL_LO = 5'h06;
  localparam logic [MODE_W-1:0] MD_LIM_LVL_HI = 5'h07;
  localparam logic [MODE_W-1:0] MD_OS_SW = 5'h08;
  localparam logic [MODE_W-1:0] MD_OS_RISE = 5'h09;
  localparam logic [MODE_W-1:0] MD_OS_FALL = 5'h0a;
  localparam logic [MODE_W-1:0] MD_OS_ANY = 5'h0b;
  localparam logic [MODE_W-1:0] MD_OS_LIM_RISE = 5'h0c;
  localparam logic [MODE_W-1:0] MD_OS_LIM_FALL = 5'h0d;
  localparam logic [MODE_W-1:0] MD_OS_RISE_LO = 5'h0e;
  localparam logic [MODE_W-1:0] MD_OS_FALL_HI = 5'h0f;
  localparam logic [MODE_W-1:0] MD_MS_RISE = 5'h11;
  localparam logic [MODE_W-1:0] MD_MS_FALL = 5'h12;
  localparam logic [MODE_W-1:0] MD_MS_ANY = 5'h13;
  localparam logic [MODE_W-1:0] MD_OS_LVL_LO = 5'h16;
  localparam logic [MODE_W-1:0] MD_OS_LVL_HI = 5'h17;

  // ----------------------------------------------------------------------
  // values and delays, in timer clocks
  // ----------------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [POST_W-1:0] POST_ZERO = 4'h0;
  localparam logic [POST_W-1:0] POST_ONE = 4'h1;
  localparam logic [1:0] RESTART_DLY = 2'h2;
  localparam logic [1:0] DLY_ZERO = 2'h0;
  localparam logic [1:0] DLY_ONE = 2'h1;

  // control bits that software drives
  typedef struct packed {
    logic run_en;
    logic [MODE_W-1:0] mode;
    logic [POST_W-1:0] postscale_select;
  } pth_ctrl_t;

  // state visible to software and the compare unit
  typedef struct packed {
    logic [CNT_W-1:0] count_value;
    logic run_clr;
    logic period_match;
  } pth_stat_t;

endpackage : pth_pkg

// ### design/pth_sync.sv
// two-stage synchroniser for a level arriving from another domain
`timescale 1ns/100ps
module pth_sync #(
  parameter int unsigned WIDTH = 1
) (
  input wire logic mclk_i,              // core clock
  input wire logic srst_i,              // sync reset, high
  input wire logic [WIDTH-1:0] d_i,     // async level
  output logic [WIDTH-1:0] q_o          // synchronised level
);

  logic [WIDTH-1:0] meta_r;

  // ----------------------------------------------------------------------
  // first stage feeds only the second stage
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      meta_r <= '0;
      q_o <= '0;
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end

endmodule : pth_sync

// ### design/pth_timer.sv
// period timer with gate, hardware limit, one-shot and monostable modes
//
// Operation
// - software gate counts each timer tick while run bit set, else holds
// - on period match the count goes to zero next tick, keeps counting
// - mode 00001 counts while input high, 00010 while low, run bit set
// - edge limit modes clear on any, rising, or falling input edge
// - after early edge reset, counting resumes after two timer ticks
// - level limit holds counter reset at low (00110) or high (00111)
// - level limit modes ignore the input while run bit is clear
// - level limit clears on match or two ticks into reset level
// - restart two ticks after reset level ends, next tick after match
// - one-shot 100/101 start on rising/falling edge and reset on it
// - one-shot 110/111 start on edge, hold reset at low/high level
// - edge-started modes need a fresh edge after run bit set again
// - one-shot match clears run bit and stops counter at zero
// - monostable match stops counter at zero, run bit stays set
// - level one-shot 10110/10111 run at high/low, reset at low/high
// - interrupt when postscaler count reaches selected ratio 1:1..1:16
// - run bit and input pass two-stage core-clock synchronisers, then are sampled on timer ticks
// - with instruction clock, same synchroniser gives one period delay
// - five-bit mode field selects the operating mode
// - monostable starts on rising 10001, falling 10010, any 10011
`timescale 1ns/100ps
module pth_timer
  import pth_pkg::*;
#(
  parameter int unsigned SYNC_W = 2
) (
  input wire logic mclk_i,                     // core clock, 250 MHz
  input wire logic srst_i,                     // sync reset, high
  input wire logic tick_i,                     // timer clock enable pulse
  input wire pth_pkg::pth_ctrl_t ctrl_i,       // run, mode, postscale
  input wire logic [pth_pkg::CNT_W-1:0] period_value_i, // period
  input wire logic clr_scalers_i,              // write clears postscaler
  input wire logic external_reset_input_i,     // async trigger input
  output pth_pkg::pth_stat_t stat_o,           // count and events
  output logic postscaled_o,                   // one-core-cycle period event
  output logic running_o                       // counter advancing
);

  // ----------------------------------------------------------------------
  // synchronisers for the run bit and the trigger input
  // ----------------------------------------------------------------------
  logic [SYNC_W-1:0] sync_q;
  logic run_s;
  logic ers_s;

  pth_sync #(.WIDTH(SYNC_W)) u_sync (
    .mclk_i(mclk_i),
    .srst_i(srst_i),
    .d_i({ctrl_i.run_en, external_reset_input_i}),
    .q_o(sync_q)
  );

  // second stage sampled on the next timer tick: two core cycles plus up to one timer clock
  logic run_t_r;
  logic ers_t_r;
  logic ers_prev_r;

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      run_t_r <= 1'b0;
      ers_t_r <= 1'b0;
      ers_prev_r <= 1'b0;
    end else if (tick_i) begin
      run_t_r <= sync_q[1];
      ers_t_r <= sync_q[0];
      ers_prev_r <= ers_t_r;
    end
  end

  // the one-shot clears the run bit internally; software sees run_clr
  logic run_kill_r;
  assign run_s = run_t_r & ~run_kill_r;
  assign ers_s = ers_t_r;

  // ----------------------------------------------------------------------
  // edge and level decoding
  // ----------------------------------------------------------------------
  logic rise;
  logic fall;
  assign rise = ers_s & ~ers_prev_r;
  assign fall = ~ers_s & ers_prev_r;

  // selects the trigger edge from a two-bit code derived from the mode: 1 rise, 2 fall, 3 either
  function automatic logic edge_sel(input logic [1:0] sel, input logic r,
                                    input logic f);
    case (sel)
      2'h1: edge_sel = r;
      2'h2: edge_sel = f;
      2'h3: edge_sel = r | f;
      default: edge_sel = 1'b0;
    endcase
  endfunction : edge_sel

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,   // waiting for start condition
    ST_RUN = 5'b00010,    // counting
    ST_HOLD = 5'b00100,   // held in reset by trigger
    ST_DLY = 5'b01000,    // two-tick restart delay
    ST_DONE = 5'b10000    // stopped at zero after match
  } pth_state_t;

  pth_state_t state_r;
  pth_state_t state_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [1:0] dly_r;
  logic [1:0] dly_nxt;
  logic [MODE_W-1:0] mode;
  logic match;
  logic kill_nxt;
  logic adv;

  assign mode = ctrl_i.mode;
  assign match = (cnt_r == period_value_i);

  // ----------------------------------------------------------------------
  // mode behaviour per timer tick
  // ----------------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    dly_nxt = dly_r;
    kill_nxt = 1'b0;
    adv = 1'b0;
    case (mode)
      // ---- free running gate modes ----
      MD_SW_GATE, MD_HW_GATE_HI, MD_HW_GATE_LO: begin
        state_nxt = ST_RUN;
        if (run_s && (mode == MD_SW_GATE ||
            (mode == MD_HW_GATE_HI && ers_s) ||
            (mode == MD_HW_GATE_LO && !ers_s))) begin
          adv = 1'b1;
          cnt_nxt = match ? CNT_ZERO : cnt_r + CNT_ONE;
        end
      end
      // ---- edge hardware limit ----
      MD_LIM_ANY, MD_LIM_RISE, MD_LIM_FALL: begin
        if (!run_s) begin
          state_nxt = ST_RUN;
        end else if (edge_sel(mode[1:0] + 2'h3 == 2'h2 ? 2'h3 :
                     (mode == MD_LIM_RISE ? 2'h1 : 2'h2), rise, fall)) begin
          cnt_nxt = CNT_ZERO;
          state_nxt = ST_DLY;
          dly_nxt = DLY_ONE;
        end else if (state_r == ST_DLY) begin
          if (dly_r == DLY_ZERO) begin
            state_nxt = ST_RUN;
          end else begin
            dly_nxt = dly_r - DLY_ONE;
          end
        end else begin
          adv = 1'b1;
          state_nxt = ST_RUN;
          cnt_nxt = match ? CNT_ZERO : cnt_r + CNT_ONE;
        end
      end
      // ---- level hardware limit ----
      MD_LIM_LVL_LO, MD_LIM_LVL_HI: begin
        if (!run_s) begin
          state_nxt = ST_RUN;
        end else if (ers_s == mode[0]) begin
          // reset level: clears after two ticks at level
          if (state_r == ST_HOLD) begin
            cnt_nxt = CNT_ZERO;
          end else if (state_r == ST_DLY) begin
            state_nxt = ST_HOLD;
            cnt_nxt = CNT_ZERO;
          end else begin
            state_nxt = ST_DLY;
            adv = 1'b1;
            cnt_nxt = match ? CNT_ZERO : cnt_r + CNT_ONE;
          end
        end else if (state_r == ST_HOLD) begin
          state_nxt = ST_IDLE;
        end else if (state_r == ST_IDLE) begin
          state_nxt = ST_RUN;
        end else begin
          state_nxt = ST_RUN;
          adv = 1'b1;
          cnt_nxt = match ? CNT_ZERO : cnt_r + CNT_ONE;
        end
      end
      // ---- one-shot and monostable ----
      MD_OS_SW, MD_OS_RISE, MD_OS_FALL, MD_OS_ANY, MD_OS_LIM_RISE,
      MD_OS_LIM_FALL, MD_OS_RISE_LO, MD_OS_FALL_HI,
      MD_MS_RISE, MD_MS_FALL, MD_MS_ANY: begin
        if (!run_s) begin
          state_nxt = ST_IDLE;
        end else begin
          case (state_r)
            ST_IDLE, ST_DONE: begin
              if ((state_r == ST_IDLE && mode == MD_OS_SW) ||
                  ((mode[4] || state_r == ST_IDLE) &&
                   edge_sel(mode[2] ? {mode[0], ~mode[0]} : mode[1:0],
                            rise, fall))) begin
                state_nxt = ST_RUN;
                cnt_nxt = CNT_ZERO;
              end
            end
            default: begin
              if ((mode == MD_OS_RISE_LO && !ers_s) ||
                  (mode == MD_OS_FALL_HI && ers_s)) begin
                cnt_nxt = CNT_ZERO;
                state_nxt = ST_HOLD;
              end else if (state_r == ST_HOLD) begin
                state_nxt = ST_RUN;
              end else if (mode[2] && !mode[1] &&
                           edge_sel({mode[0], ~mode[0]}, rise, fall)) begin
                cnt_nxt = CNT_ZERO;
              end else if (match) begin
                cnt_nxt = CNT_ZERO;
                state_nxt = ST_DONE;
                kill_nxt = ~mode[4];
                adv = 1'b1;
              end else begin
                adv = 1'b1;
                cnt_nxt = cnt_r + CNT_ONE;
              end
            end
          endcase
        end
      end
      // ---- level-triggered one-shot ----
      MD_OS_LVL_LO, MD_OS_LVL_HI: begin
        if (!run_s || ers_s == mode[0]) begin
          cnt_nxt = CNT_ZERO;
          state_nxt = ST_IDLE;
        end else if (match) begin
          cnt_nxt = CNT_ZERO;
          kill_nxt = 1'b1;
          adv = 1'b1;
        end else begin
          adv = 1'b1;
          cnt_nxt = cnt_r + CNT_ONE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // counter, state and internal run-bit clear
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= CNT_ZERO;
      dly_r <= DLY_ZERO;
    end else if (tick_i) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      dly_r <= dly_nxt;
    end
  end

  // kill holds until software drops the run bit, then re-arms
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      run_kill_r <= 1'b0;
    end else if (tick_i) begin
      if (kill_nxt) begin
        run_kill_r <= 1'b1;
      end else if (!run_t_r) begin
        run_kill_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // postscaler: ratio is select + 1
  // ----------------------------------------------------------------------
  logic [POST_W-1:0] post_r;
  logic period_evt;
  assign period_evt = adv & match;

  always_ff @(posedge mclk_i) begin
    if (srst_i || clr_scalers_i) begin
      post_r <= POST_ZERO;
      postscaled_o <= 1'b0;
    end else if (tick_i) begin
      postscaled_o <= 1'b0;
      if (period_evt) begin
        if (post_r == ctrl_i.postscale_select) begin
          post_r <= POST_ZERO;
          postscaled_o <= 1'b1;
        end else begin
          post_r <= post_r + POST_ONE;
        end
      end
    end else begin
      postscaled_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // registered status outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      stat_o <= '0;
      running_o <= 1'b0;
    end else begin
      stat_o.count_value <= cnt_r;
      stat_o.run_clr <= run_kill_r;
      stat_o.period_match <= tick_i & period_evt;
      running_o <= tick_i & adv;
    end
  end

endmodule : pth_timer

// ### verification/pth_ers_model.sv
// trigger source model: the peripheral driving the timer's reset input
`timescale 1ns/100ps
module pth_ers_model #(
  parameter int unsigned MIN_TICKS = 6
) (
  input wire logic mclk_i, // core clock
  input wire logic srst_i, // sync reset, high
  input wire logic tick_i, // timer clock pulse
  input wire logic want_i, // level asked for by the bench
  output logic ers_o // external reset input level
);
  logic [3:0] gap_r;
  // ----------------------------------------------------------------
  // spacing
  // ----------------------------------------------------------------
  // a change waits out the gap, so edges and levels stay legal
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      ers_o <= 1'b0;
      gap_r <= 4'h0;
    end else if (want_i != ers_o && gap_r >= 4'(MIN_TICKS)) begin
      ers_o <= want_i;
      gap_r <= 4'h0;
    end else if (tick_i && gap_r != 4'hf) begin
      gap_r <= gap_r + 4'h1;
    end
  end
endmodule : pth_ers_model

// ### verification/pth_timer_monitor.sv
// checker: port-level assertions for the period timer
`timescale 1ns/100ps
module pth_timer_monitor
  import pth_pkg::*;
(
  input wire logic mclk_i, // core clock
  input wire logic srst_i, // sync reset
  input wire logic tick_i, // timer tick
  input wire pth_pkg::pth_ctrl_t ctrl_i, // control bits
  input wire logic external_reset_input_i, // trigger input
  input wire pth_pkg::pth_stat_t stat_o, // count and events
  input wire logic postscaled_o, // postscaled event
  input wire logic running_o // advance pulse
);
  logic [5:0] idle_r, lvl_r, rsv_r;
  logic rsv;
  assign rsv = ctrl_i.mode inside {5'h10, 5'h14, 5'h15} ||
               ctrl_i.mode[4:3] == 2'b11;
  function automatic logic [5:0] sat(logic [5:0] c, logic hold);
    return hold ? ((c == 6'h3f) ? c : c + 6'h01) : 6'h00;
  endfunction : sat
  // ----------------------------------------------------------------
  // how long each holding condition has lasted
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      idle_r <= 6'h00;
      lvl_r <= 6'h00;
      rsv_r <= 6'h00;
    end else begin
      idle_r <= sat(idle_r, ctrl_i.mode == MD_SW_GATE && !ctrl_i.run_en);
      lvl_r <= sat(lvl_r, ctrl_i.mode == MD_LIM_LVL_HI && ctrl_i.run_en &&
                   external_reset_input_i);
      rsv_r <= sat(rsv_r, rsv);
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  // waits of 40 cover both synchroniser stages plus two ticks
  count_step_a: assert property ($changed(stat_o.count_value) |->
    stat_o.count_value == $past(stat_o.count_value) + 8'h01 ||
    stat_o.count_value == 8'h00) else $error("count jumped");
  // count output lags the counter by one cycle, so look two edges back
  count_tick_a: assert property (!$past(tick_i, 2) |->
    $stable(stat_o.count_value)) else $error("count moved off tick");
  match_pulse_a: assert property (stat_o.period_match |=>
    !stat_o.period_match) else $error("match pulse too long");
  post_pulse_a: assert property (postscaled_o |=> !postscaled_o)
    else $error("postscaled pulse too long");
  post_match_a: assert property (postscaled_o |->
    stat_o.period_match) else $error("postscaled without match");
  gate_hold_a: assert property (idle_r >= 6'h28 |->
    $stable(stat_o.count_value)) else $error("count moved with run off");
  lvl_reset_a: assert property (lvl_r >= 6'h28 |->
    stat_o.count_value == 8'h00) else $error("level reset not held");
  resv_idle_a: assert property (rsv_r >= 6'h08 |-> !running_o &&
    $stable(stat_o.count_value)) else $error("reserved mode counted");
  cover property (stat_o.period_match);
  cover property (postscaled_o);
  cover property ($rose(stat_o.run_clr));
endmodule : pth_timer_monitor

bind pth_timer pth_timer_monitor i_pth_timer_monitor (
  .mclk_i(mclk_i), .srst_i(srst_i), .tick_i(tick_i), .ctrl_i(ctrl_i),
  .external_reset_input_i(external_reset_input_i), .stat_o(stat_o),
  .postscaled_o(postscaled_o), .running_o(running_o));

// ### verification/tb_top.sv
// testbench: directed scenarios for the period timer
`timescale 1ns/100ps
module tb_top;
  import pth_pkg::*;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic tick_i = 1'b0;
  logic clr_scalers_i = 1'b0;
  logic want = 1'b0;
  logic ers;
  logic postscaled_o;
  logic running_o;
  logic [1:0] tdiv = 2'h0;
  logic [7:0] period_value_i = 8'h00;
  pth_ctrl_t ctrl_i = '0;
  pth_stat_t stat_o;
  int n_errors = 0;
  int n_compared = 0;
  int n_match = 0;
  int n_post = 0;

  pth_timer i_pth_timer (.mclk_i(mclk_i), .srst_i(srst_i), .tick_i(tick_i),
    .ctrl_i(ctrl_i), .period_value_i(period_value_i),
    .clr_scalers_i(clr_scalers_i), .external_reset_input_i(ers),
    .stat_o(stat_o), .postscaled_o(postscaled_o), .running_o(running_o));
  pth_ers_model i_pth_ers_model (.mclk_i(mclk_i), .srst_i(srst_i),
    .tick_i(tick_i), .want_i(want), .ers_o(ers));

  // ----------------------------------------------------------------
  // clock, tick and event tallies
  // ----------------------------------------------------------------
  always #2 mclk_i = ~mclk_i;
  // one timer tick every fourth core cycle, never back to back
  always @(posedge mclk_i) begin
    tdiv <= tdiv + 2'h1;
    tick_i <= (tdiv == 2'h3);
  end
  always @(posedge mclk_i) begin
    if (stat_o.period_match === 1'b1) n_match++;
    if (postscaled_o === 1'b1) n_post++; // postscaled period event
  end

  task automatic cyc(int n);
    repeat (n) @(posedge mclk_i);
  endtask : cyc
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic setc(logic r, logic [4:0] m, logic [3:0] ps, logic [7:0] p);
    @(posedge mclk_i);
    ctrl_i <= '{r, m, ps};
    period_value_i <= p;
  endtask : setc
  // run off long enough to drop any pending start, then on again
  task automatic rearm(logic [4:0] m, logic [7:0] p);
    setc(1'b0, m, 4'h0, p);
    cyc(40);
    setc(1'b1, m, 4'h0, p);
  endtask : rearm
  task automatic do_reset();
    @(posedge mclk_i);
    srst_i <= 1'b1;
    cyc(5);
    srst_i <= 1'b0;
  endtask : do_reset

  task automatic t_sw();
    logic [7:0] mx;
    logic [7:0] c;
    mx = 8'h00;
    rearm(MD_SW_GATE, 8'h03);
    repeat (80) begin
      @(posedge mclk_i);
      if (stat_o.count_value > mx) mx = stat_o.count_value;
    end
    chk(mx, 8'h03);
    setc(1'b0, MD_SW_GATE, 4'h0, 8'h03);
    cyc(40);
    c = stat_o.count_value;
    cyc(40);
    chk(stat_o.count_value, c);
    $display("test sw_gate done");
  endtask : t_sw

  task automatic t_post();
    logic [3:0] tab [3] = '{4'h0, 4'h2, 4'hf};
    int m0;
    int p0;
    int k;
    foreach (tab[i]) begin
      setc(1'b0, MD_SW_GATE, tab[i], 8'h01);
      clr_scalers_i <= 1'b1;
      cyc(1);
      clr_scalers_i <= 1'b0;
      cyc(40);
      m0 = n_match;
      p0 = n_post;
      k = 0;
      setc(1'b1, MD_SW_GATE, tab[i], 8'h01);
      while (n_match - m0 < 2 * (tab[i] + 1) && k < 3000) begin
        cyc(1);
        k++;
      end
      cyc(1);
      chk(8'(n_post - p0), 8'h02);
    end
    $display("test postscale done");
  endtask : t_post

  task automatic t_gate();
    logic [7:0] c;
    for (int i = 0; i < 2; i++) begin
      want <= i[0];
      rearm(i[0] ? MD_HW_GATE_LO : MD_HW_GATE_HI, 8'hff);
      cyc(60);
      c = stat_o.count_value;
      cyc(40);
      chk(stat_o.count_value, c);
      want <= ~i[0];
      cyc(60);
      chk({7'h0, stat_o.count_value != c}, 8'h01);
    end
    $display("test hw_gate done");
  endtask : t_gate

  task automatic t_edge();
    logic [7:0] c;
    int m0;
    int k;
    rearm(MD_LIM_RISE, 8'hff);
    cyc(80);
    c = stat_o.count_value;
    m0 = n_match;
    want <= 1'b1;
    k = 0;
    // find the clear, then zero must stand two more ticks
    while (stat_o.count_value != 8'h00 && k < 40) begin
      cyc(1);
      k++;
    end
    cyc(8);
    chk(stat_o.count_value, 8'h00);
    cyc(24);
    chk({7'h0, stat_o.count_value < c}, 8'h01);
    chk({7'h0, stat_o.count_value != 8'h00}, 8'h01);
    chk(8'(n_match - m0), 8'h00);
    $display("test edge_limit done");
  endtask : t_edge

  task automatic t_lvl();
    logic [7:0] c;
    for (int i = 0; i < 2; i++) begin
      want <= ~i[0];
      rearm(i[0] ? MD_LIM_LVL_HI : MD_LIM_LVL_LO, 8'hff);
      cyc(40);
      want <= i[0];
      cyc(80);
      chk(stat_o.count_value, 8'h00);
      want <= ~i[0];
      cyc(60);
      chk({7'h0, stat_o.count_value != 8'h00}, 8'h01);
      setc(1'b0, i[0] ? MD_LIM_LVL_HI : MD_LIM_LVL_LO, 4'h0, 8'hff);
      cyc(40);
      c = stat_o.count_value;
      want <= i[0];
      cyc(60);
      chk(stat_o.count_value, c);
    end
    $display("test level_limit done");
  endtask : t_lvl

  task automatic t_os();
    logic [7:0] c;
    int m0;
    do_reset();
    want <= 1'b0;
    rearm(MD_OS_RISE, 8'h05);
    c = stat_o.count_value;
    cyc(40);
    chk(stat_o.count_value, c);
    m0 = n_match;
    want <= 1'b1;
    cyc(120);
    chk(8'(n_match - m0), 8'h01);
    chk(stat_o.count_value, 8'h00);
    chk({7'h0, stat_o.run_clr}, 8'h01);
    setc(1'b0, MD_OS_RISE, 4'h0, 8'h05);
    cyc(40);
    chk({7'h0, stat_o.run_clr}, 8'h00);
    $display("test one_shot done");
  endtask : t_os

  task automatic t_ms();
    int m0;
    do_reset();
    want <= 1'b0;
    rearm(MD_MS_RISE, 8'h05);
    m0 = n_match;
    want <= 1'b1;
    cyc(120);
    chk(8'(n_match - m0), 8'h01);
    chk(stat_o.count_value, 8'h00);
    chk({7'h0, stat_o.run_clr}, 8'h00);
    want <= 1'b0;
    cyc(30);
    want <= 1'b1;
    cyc(120);
    chk(8'(n_match - m0), 8'h02);
    $display("test monostable done");
  endtask : t_ms

  // edge-limit one-shot: start, early clear, self stop; then level one-shot
  task automatic t_oslim();
    logic [7:0] c;
    want <= 1'b0;
    rearm(MD_OS_LIM_RISE, 8'h30);
    cyc(20);
    want <= 1'b1;
    cyc(60);
    c = stat_o.count_value;
    chk({7'h0, c != 8'h00}, 8'h01);
    want <= 1'b0;
    cyc(30);
    want <= 1'b1;
    cyc(24);
    chk({7'h0, stat_o.count_value < c}, 8'h01);
    cyc(240);
    chk(stat_o.count_value, 8'h00);
    chk({7'h0, stat_o.run_clr}, 8'h01);
    setc(1'b0, MD_OS_LIM_RISE, 4'h0, 8'h30);
    cyc(40);
    want <= 1'b0;
    setc(1'b1, MD_OS_LVL_LO, 4'h0, 8'h30);
    cyc(40);
    chk(stat_o.count_value, 8'h00);
    want <= 1'b1;
    cyc(40);
    chk({7'h0, stat_o.count_value != 8'h00}, 8'h01);
    want <= 1'b0;
    cyc(28);
    chk(stat_o.count_value, 8'h00);
    $display("test oneshot_limit done");
  endtask : t_oslim

  task automatic t_resv();
    logic [4:0] tab [4] = '{5'h10, 5'h14, 5'h15, 5'h18};
    logic [7:0] c;
    foreach (tab[i]) begin
      setc(1'b1, tab[i], 4'h0, 8'hff);
      cyc(8);
      c = stat_o.count_value;
      cyc(60);
      chk(stat_o.count_value, c);
    end
    $display("test reserved done");
  endtask : t_resv

  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    cyc(5);
    srst_i <= 1'b0;
    t_sw();
    t_post();
    t_gate();
    t_edge();
    t_lvl();
    t_os();
    t_ms();
    t_oslim();
    t_resv();
    finish_test();
  end
  // tests need about 3300 cycles; three times that (10000 cycles) means a hang
  initial begin
    #40000;
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end
endmodule : tb_top
